// ### ssm_pkg.sv
// Purpose: shared constants and types for the synchronous serial master transmitter
// Assumes: 32-bit AXI4-Lite register access, one register per aligned word
// Notes:   offsets are byte addresses; field positions index the control and status words
package ssm_pkg;

	// register byte offsets
	localparam logic [3:0] SSM_OFS_CTRL   = 4'h0;
	localparam logic [3:0] SSM_OFS_DIV    = 4'h4;
	localparam logic [3:0] SSM_OFS_TXDATA = 4'h8;
	localparam logic [3:0] SSM_OFS_STATUS = 4'hC;
	localparam int         SSM_ADDR_W     = 4;

	// control word bit positions
	localparam int SSM_B_SYNC   = 0;
	localparam int SSM_B_MASTER = 1;
	localparam int SSM_B_SRXEN  = 2;
	localparam int SSM_B_CRXEN  = 3;
	localparam int SSM_B_PORTEN = 4;
	localparam int SSM_B_IDLPOL = 5;
	localparam int SSM_B_TXON   = 6;
	localparam int SSM_B_NINEEN = 7;
	localparam int SSM_B_NINEV  = 8;
	localparam int SSM_B_HIRATE = 9;
	localparam int SSM_B_WIDDIV = 10;
	localparam int SSM_B_TXIRQ  = 11;
	localparam int SSM_B_GLBIRQ = 12;
	localparam int SSM_B_PERGT  = 13;
	localparam int SSM_CTRL_W   = 14;

	// status word bit positions
	localparam int SSM_S_TXBE   = 0;
	localparam int SSM_S_BUSY   = 1;
	localparam int SSM_S_IRQ    = 2;
	localparam int SSM_S_DTLVL  = 3;
	localparam int SSM_S_CKLVL  = 4;

	// reset values and bus answers
	localparam logic [SSM_CTRL_W-1:0] SSM_CTRL_RST = 14'h0000;
	localparam logic [15:0]           SSM_DIV_RST  = 16'h0000;
	localparam logic [1:0]            SSM_RESP_OK  = 2'h0;
	localparam logic [1:0]            SSM_RESP_ERR = 2'h2;

	// character lengths
	localparam logic [3:0] SSM_LEN8 = 4'h8;
	localparam logic [3:0] SSM_LEN9 = 4'h9;

	typedef struct packed {
		logic peripheral_irq_gate;
		logic global_irq_enable;
		logic transmit_interrupt_enable;
		logic wide_divisor_select;
		logic high_rate_select;
		logic ninth_transmit_bit_value;
		logic ninth_bit_transmit_enable;
		logic transmit_enable;
		logic clock_idle_polarity;
		logic serial_port_enable;
		logic continuous_receive_enable;
		logic single_receive_enable;
		logic clock_source_master_select;
		logic sync_mode_select;
	} ssm_ctrl_t;

	typedef enum logic [1:0] {
		SSM_IDLE,
		SSM_LEAD,
		SSM_TRAIL
	} ssm_state_t;

endpackage

// ### ssm_tx.sv
// Purpose: synchronous master transmitter of the enhanced serial port, AXI4-Lite slave
// Assumes: aclk 10 MHz, synchronous active-low reset, pins resolved by the bench
// Notes:   receive paths are not built; receive enables turn the data driver off and keep the master clock driver on
//
// Overview of operation
// - synchronous frames carry only data bits, no start or stop bits
// - one shared data line: half-duplex, never send and receive together
// - sync select 1 gives synchronous mode; clock source 1 makes us master
// - both receive enables 0 means transmit; either set means receive
// - serial port enable switches the port on; cleared it stays inactive
// - master drives clock pin; its driver turns on when sync tx or rx set
// - exactly one clock cycle per data bit, none extra
// - data changes on leading edge, holds through trailing edge
// - idle polarity 1: clock idles high, data changes on falling edge
// - idle polarity 0: clock idles low, data changes on rising edge
// - master transmit drives data pin; data and clock drivers both enabled
// - writing the holding buffer starts a transmission
// - new character waits in holding buffer while shifter still busy
// - empty shifter loads at once from buffer; shifting starts right after
// - the shift register is not in the register map
// - divisor and rate bits are set before a character is loaded
// - transmitting needs the transmit enable bit set
// - ninth-bit enable makes each character nine bits long
// - ninth bit value comes from its own control bit, set before writing
// - transmit interrupt needs its enable, global enable and peripheral gate
`timescale 1ns/1ps
module ssm_tx
	import ssm_pkg::*;
#(
	parameter int DIV_W = 16
) (
	// clock and reset
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	// axi4-lite write address
	input  wire logic [SSM_ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	// axi4-lite read address
	input  wire logic [SSM_ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	// axi4-lite read data
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	// clock line pin
	input  wire logic                   clock_line_pin_i,
	output logic                        clock_line_pin_o,
	output logic                        clock_line_pin_oe_n,
	// data line pin
	input  wire logic                   data_line_pin_i,
	output logic                        data_line_pin_o,
	output logic                        data_line_pin_oe_n,
	// gated transmit interrupt
	output logic                        tx_irq
);

	// elaboration check: divisor needs a high byte and must fit a 16-bit field
	if (DIV_W < 9 || DIV_W > 16) begin : g_bad_div
		$error("ssm_tx: DIV_W must be 9..16");
	end

	// elaboration check: the control struct must match the control word width
	if ($bits(ssm_ctrl_t) != SSM_CTRL_W) begin : g_bad_ctrl
		$error("ssm_tx: control struct width mismatch");
	end

	// registers
	ssm_ctrl_t              ctrl_ff;
	logic [DIV_W-1:0]       div_ff;
	logic [8:0]             hold_ff;      // transmit_holding_buffer, ninth bit captured on write
	logic                   hold_full_ff;
	logic [8:0]             shift_ff;     // transmit_shift_register, not mapped
	logic [3:0]             bits_left_ff;
	logic [DIV_W:0]         half_cnt_ff;
	ssm_state_t             state_ff;

	// pin synchronisers
	logic                   dt_meta_ff, dt_sync_ff;
	logic                   ck_meta_ff, ck_sync_ff;

	// axi bookkeeping
	logic                   aw_have_ff, w_have_ff;
	logic [SSM_ADDR_W-1:0]  aw_addr_ff;
	logic [31:0]            w_data_ff;
	logic [3:0]             w_strb_ff;

	// derived modes
	logic                   port_on, master_on, rx_cfg, tx_mode, drv_clk;
	logic                   load_shift, wr_fire, wr_tx, half_done;
	logic                   bit_end, last_bit;
	logic [DIV_W:0]         half_len;
	logic [8:0]             nxt_hold;

	assign port_on   = ctrl_ff.serial_port_enable;
	assign master_on = port_on & ctrl_ff.sync_mode_select
	                 & ctrl_ff.clock_source_master_select;
	assign rx_cfg    = ctrl_ff.single_receive_enable | ctrl_ff.continuous_receive_enable;
	assign tx_mode   = master_on & ~rx_cfg & ctrl_ff.transmit_enable;
	assign drv_clk   = master_on & (rx_cfg | ctrl_ff.transmit_enable);

	// high_rate_select has no effect on the synchronous clock; narrow mode uses low byte
	assign half_len  = ctrl_ff.wide_divisor_select
	                 ? {1'b0, div_ff} + 1'b1
	                 : {{(DIV_W-7){1'b0}}, div_ff[7:0]} + 1'b1;
	assign half_done = (half_cnt_ff >= half_len - 1'b1);

	// write side: both address and data latched, response slot free
	assign wr_fire   = aw_have_ff & w_have_ff & ~s_axi_bvalid;
	assign wr_tx     = wr_fire & (aw_addr_ff == SSM_OFS_TXDATA) & w_strb_ff[0];
	assign nxt_hold  = {ctrl_ff.ninth_transmit_bit_value, w_data_ff[7:0]};
	assign load_shift = tx_mode & hold_full_ff & (state_ff == SSM_IDLE);
	// end of a trailing half marks one bit gone
	assign bit_end    = tx_mode & (state_ff == SSM_TRAIL) & half_done;
	assign last_bit   = (bits_left_ff == 4'h1);

	// two-flop synchronisers for the pin inputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dt_meta_ff <= 1'b0;
			dt_sync_ff <= 1'b0;
			ck_meta_ff <= 1'b0;
			ck_sync_ff <= 1'b0;
		end else begin
			dt_meta_ff <= data_line_pin_i;
			dt_sync_ff <= dt_meta_ff;
			ck_meta_ff <= clock_line_pin_i;
			ck_sync_ff <= ck_meta_ff;
		end
	end

	// write address capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_ff    <= 1'b0;
			aw_addr_ff    <= '0;
			s_axi_awready <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_have_ff <= 1'b0;
			end
			// one-cycle ready, lowered after each acceptance
			s_axi_awready <= ~aw_have_ff & ~s_axi_awready & ~(s_axi_awvalid & s_axi_awready) & s_axi_awvalid;
		end
	end

	// write data capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_ff    <= 1'b0;
			w_data_ff    <= '0;
			w_strb_ff    <= '0;
			s_axi_wready <= 1'b0;
		end else begin
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_have_ff <= 1'b0;
			end
			s_axi_wready <= ~w_have_ff & ~s_axi_wready & s_axi_wvalid;
		end
	end

	// write response; unmapped offsets answer slverr
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= SSM_RESP_OK;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (aw_addr_ff[1:0] != 2'h0) ? SSM_RESP_ERR : SSM_RESP_OK;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// control register, byte enables honoured
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff <= SSM_CTRL_RST;
		end else if (wr_fire && aw_addr_ff == SSM_OFS_CTRL) begin
			if (w_strb_ff[0])
				ctrl_ff[7:0] <= w_data_ff[7:0];
			if (w_strb_ff[1])
				ctrl_ff[SSM_CTRL_W-1:8] <= w_data_ff[SSM_CTRL_W-1:8];
		end
	end

	// divisor register; narrow mode only uses the low byte
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_ff <= SSM_DIV_RST[DIV_W-1:0];
		end else if (wr_fire && aw_addr_ff == SSM_OFS_DIV) begin
			if (w_strb_ff[0])
				div_ff[7:0] <= w_data_ff[7:0];
			if (w_strb_ff[1])
				div_ff[DIV_W-1:8] <= w_data_ff[DIV_W-1:8];
		end
	end

	// holding buffer: a write in the hand-off cycle wins over the clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold_ff      <= '0;
			hold_full_ff <= 1'b0;
		end else if (!port_on) begin
			hold_full_ff <= 1'b0;
		end else if (wr_tx) begin
			hold_ff      <= nxt_hold;
			hold_full_ff <= 1'b1;
		end else if (load_shift) begin
			hold_full_ff <= 1'b0;
		end
	end

	// half-period counter; restarts at every phase boundary and while idle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			half_cnt_ff <= '0;
		end else if (!tx_mode || state_ff == SSM_IDLE || half_done) begin
			half_cnt_ff <= '0;
		end else begin
			half_cnt_ff <= half_cnt_ff + 1'b1;
		end
	end

	// phase sequencer; dropping out of transmit aborts the character in flight
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= SSM_IDLE;
		end else if (!tx_mode) begin
			state_ff <= SSM_IDLE;
		end else begin
			unique case (state_ff)
				SSM_IDLE: begin
					if (load_shift)
						state_ff <= SSM_LEAD;
				end
				SSM_LEAD: begin
					// leading half over: clock returns to idle, data stays put
					if (half_done)
						state_ff <= SSM_TRAIL;
				end
				SSM_TRAIL: begin
					// stop after the last bit; no extra clock cycles
					if (half_done)
						state_ff <= last_bit ? SSM_IDLE : SSM_LEAD;
				end
			endcase
		end
	end

	// bit counter: data bits only, no start or stop framing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bits_left_ff <= '0;
		end else if (!tx_mode) begin
			bits_left_ff <= '0;
		end else if (load_shift) begin
			bits_left_ff <= ctrl_ff.ninth_bit_transmit_enable ? SSM_LEN9 : SSM_LEN8;
		end else if (bit_end) begin
			bits_left_ff <= bits_left_ff - 1'b1;
		end
	end

	// transmit_shift_register: loaded from the buffer, emptied lsb first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shift_ff <= '0;
		end else if (load_shift) begin
			shift_ff <= hold_ff;
		end else if (bit_end) begin
			shift_ff <= {1'b0, shift_ff[8:1]};
		end
	end

	// clock pin: the leading edge leaves together with the new data bit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clock_line_pin_o    <= 1'b0;
			clock_line_pin_oe_n <= 1'b1;
		end else begin
			// active phase flips the idle level set by polarity
			clock_line_pin_o    <= ctrl_ff.clock_idle_polarity ^ (state_ff == SSM_LEAD);
			clock_line_pin_oe_n <= ~drv_clk;
		end
	end

	// data pin: moves only in the leading phase, so it never changes without a clock edge;
	// between characters it keeps the last bit rather than leaking the emptied shifter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			data_line_pin_o    <= 1'b0;
			data_line_pin_oe_n <= 1'b1;
		end else begin
			if (state_ff == SSM_LEAD)
				data_line_pin_o <= shift_ff[0];
			// receive configured releases the data line, keeping it half-duplex
			data_line_pin_oe_n <= ~tx_mode;
		end
	end

	// gated transmit interrupt
	always_ff @(posedge aclk) begin
		if (!aresetn)
			tx_irq <= 1'b0;
		else
			tx_irq <= ~hold_full_ff & tx_mode & ctrl_ff.transmit_interrupt_enable
			        & ctrl_ff.global_irq_enable & ctrl_ff.peripheral_irq_gate;
	end

	// read address ready: one-cycle pulse, held off while an answer waits
	always_ff @(posedge aclk) begin
		if (!aresetn)
			s_axi_arready <= 1'b0;
		else
			s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
	end

	// read channel; the shifter has no offset of its own
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= SSM_RESP_OK;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= SSM_RESP_OK;
				s_axi_rdata  <= '0;
				unique case (s_axi_araddr)
					SSM_OFS_CTRL:   s_axi_rdata[SSM_CTRL_W-1:0] <= ctrl_ff;
					SSM_OFS_DIV:    s_axi_rdata[DIV_W-1:0] <= div_ff;
					SSM_OFS_TXDATA: s_axi_rdata <= '0;
					SSM_OFS_STATUS: begin
						s_axi_rdata[SSM_S_TXBE]  <= ~hold_full_ff;
						s_axi_rdata[SSM_S_BUSY]  <= (state_ff != SSM_IDLE);
						s_axi_rdata[SSM_S_IRQ]   <= tx_irq;
						s_axi_rdata[SSM_S_DTLVL] <= dt_sync_ff;
						s_axi_rdata[SSM_S_CKLVL] <= ck_sync_ff;
					end
					default:        s_axi_rresp <= SSM_RESP_ERR;
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

// ### ssm_tx_properties.sv
// Purpose: port-level checks of the synchronous serial master transmitter
// Assumes: bound to every ssm_tx instance, one clock domain
// Notes:   pin checks look at driven values, not at resolved wires
`timescale 1ns/1ps
module ssm_tx_properties
	import ssm_pkg::*;
(
	// clock and reset
	input wire logic                  aclk,
	input wire logic                  aresetn,
	// bus channels
	input wire logic [SSM_ADDR_W-1:0] s_axi_awaddr,
	input wire logic                  s_axi_awvalid,
	input wire logic                  s_axi_awready,
	input wire logic [1:0]            s_axi_bresp,
	input wire logic                  s_axi_bvalid,
	input wire logic                  s_axi_bready,
	input wire logic                  s_axi_arvalid,
	input wire logic                  s_axi_arready,
	input wire logic [31:0]           s_axi_rdata,
	input wire logic                  s_axi_rvalid,
	input wire logic                  s_axi_rready,
	// link pins
	input wire logic                  clock_line_pin_o,
	input wire logic                  clock_line_pin_oe_n,
	input wire logic                  data_line_pin_o,
	input wire logic                  data_line_pin_oe_n
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// data may only move together with a clock edge; a trailing edge passes as well as a leading one
	chk_data_on_edge: assert property (!data_line_pin_oe_n && !$past(data_line_pin_oe_n) &&
		$changed(data_line_pin_o) |-> $changed(clock_line_pin_o)) else $error("data moved without clock edge");
	// a driven data line always comes with a driven clock
	chk_data_needs_clk: assert property (!data_line_pin_oe_n |-> !clock_line_pin_oe_n)
		else $error("data driven without clock driver");
	// bus handshakes: pulses, holds and answers
	chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready longer than one cycle");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_b_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
		else $error("write answer late");
	chk_bad_addr: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr[1:0] != 2'h0
		|-> ##[1:4] (s_axi_bvalid && s_axi_bresp == SSM_RESP_ERR)) else $error("unaligned write not refused");
	chk_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
endmodule

bind ssm_tx ssm_tx_properties chk_u (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.clock_line_pin_o(clock_line_pin_o), .clock_line_pin_oe_n(clock_line_pin_oe_n),
	.data_line_pin_o(data_line_pin_o), .data_line_pin_oe_n(data_line_pin_oe_n));

// ### ssm_slave_model.sv
// Purpose: listening slave on the synchronous link
// Assumes: bench tells it the idle level of the clock
// Notes:   never drives the data line, it only receives
`timescale 1ns/1ps
module ssm_slave_model (
	// link wires
	input wire logic   sck,
	input wire logic   sdt,
	// bench control
	input wire logic   idle_lvl,
	input wire logic   clr,
	// collected bits, newest at the top
	output logic [15:0] rx_word,
	output int          rx_count
);
	// shift on the return to idle, using only the master clock; no output toward the data line
	always @(sck or posedge clr) begin
		if (clr) begin
			rx_word = 16'h0000;
			rx_count = 0;
		end else if (sck === idle_lvl) begin
			rx_word = {sdt, rx_word[15:1]};
			rx_count++;
		end
	end
endmodule

// ### ssm_tx_tb.sv
// Purpose: self-checking bench of the synchronous serial master transmitter
// Assumes: divisor 3 gives a link clock of 800 ns
// Notes:   clock wire pulled low, data wire pulled high when released
`timescale 1ns/1ps
module ssm_tx_tb
	import ssm_pkg::*;
;
	logic                  aclk, aresetn, clr, idle_lvl, tx_irq;
	logic [SSM_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0]           s_axi_wdata, s_axi_rdata, rdat;
	logic [3:0]            s_axi_wstrb;
	logic [1:0]            s_axi_bresp, s_axi_rresp, resp;
	logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic                  s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic                  clock_line_pin_o, clock_line_pin_oe_n, data_line_pin_o, data_line_pin_oe_n;
	logic [15:0]           rx_word;
	int                    rx_count, err_count, check_count;
	localparam logic [31:0] BASE = 32'h0000_0053;
	localparam logic [31:0] refuse_tbl [4] = '{32'h13, 32'h57, 32'h5B, 32'h43};
	localparam logic [31:0] irq_tbl [4] = '{32'h3853, 32'h1853, 32'h3053, 32'h2853};
	// released wires settle to their pull levels
	wire ck_w = clock_line_pin_oe_n ? 1'b0 : clock_line_pin_o;
	wire dt_w = data_line_pin_oe_n ? 1'b1 : data_line_pin_o;

	always #50 aclk = ~aclk;

	ssm_tx dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.clock_line_pin_i(ck_w), .clock_line_pin_o(clock_line_pin_o), .clock_line_pin_oe_n(clock_line_pin_oe_n),
		.data_line_pin_i(dt_w), .data_line_pin_o(data_line_pin_o), .data_line_pin_oe_n(data_line_pin_oe_n),
		.tx_irq(tx_irq));
	ssm_slave_model slv_u (.sck(ck_w), .sdt(dt_w), .idle_lvl(idle_lvl), .clr(clr), .rx_word(rx_word),
		.rx_count(rx_count));

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one write; address and data offered together, each dropped once taken
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task rd(input logic [3:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		rdat = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// rate first, then mode; slave cleared after the idle level has settled
	task cfg(input logic [31:0] c);
		idle_lvl <= c[SSM_B_IDLPOL];
		wr(SSM_OFS_DIV, 32'h3);
		wr(SSM_OFS_CTRL, c);
		clr <= 1'b1;
		@(posedge aclk);
		clr <= 1'b0;
	endtask
	task wait_bits(input int n);
		int k;
		for (k = 0; k < 600 && rx_count < n; k++)
			@(posedge aclk);
		repeat (20) @(posedge aclk);
	endtask
	task t_regs;
		rd(SSM_OFS_CTRL);
		chk(rdat, 32'h0);
		chk(32'(resp), 32'(SSM_RESP_OK));
		rd(SSM_OFS_STATUS);
		chk(rdat & 32'h3, 32'h1);
		chk(rdat & 32'h18, 32'h08);
		rd(SSM_OFS_TXDATA);
		chk(rdat, 32'h0);
		rd(4'h1);
		chk(32'(resp), 32'(SSM_RESP_ERR));
		wr(4'h2, 32'h53);
		chk(32'(resp), 32'(SSM_RESP_ERR));
	endtask
	task send(input logic [31:0] c, input logic [7:0] b, input int nb, input logic [8:0] e);
		cfg(c);
		wr(SSM_OFS_TXDATA, {24'h0, b});
		wait_bits(nb);
		chk(32'(rx_count), 32'(nb));
		chk(32'(rx_word >> (16 - nb)), 32'(e));
		chk(32'(ck_w), 32'(c[SSM_B_IDLPOL]));
	endtask
	// second character written while the first is still shifting
	task t_b2b;
		cfg(BASE);
		chk(32'({clock_line_pin_oe_n, data_line_pin_oe_n}), 32'h0);
		rd(SSM_OFS_DIV);
		chk(rdat, 32'h3);
		rd(SSM_OFS_CTRL);
		chk(rdat, BASE);
		wr(SSM_OFS_TXDATA, 32'h11);
		chk(32'(resp), 32'(SSM_RESP_OK));
		wr(SSM_OFS_TXDATA, 32'h22);
		rd(SSM_OFS_STATUS);
		chk(rdat & 32'h3, 32'h2);
		wait_bits(16);
		chk(32'(rx_word), 32'h2211);
		rd(SSM_OFS_STATUS);
		chk(rdat & 32'h3, 32'h1);
	endtask
	// last entry drops the port enable, which also empties the buffer
	task t_refuse;
		int i;
		for (i = 0; i < 4; i++) begin
			cfg(refuse_tbl[i]);
			wr(SSM_OFS_TXDATA, 32'h5A);
			repeat (100) @(posedge aclk);
			chk(32'(rx_count), 32'h0);
			if (refuse_tbl[i][3:2] != 2'h0)
				chk(32'({clock_line_pin_oe_n, data_line_pin_oe_n}), 32'h1);
		end
	endtask
	task t_irq;
		int i;
		for (i = 0; i < 4; i++) begin
			cfg(irq_tbl[i]);
			repeat (2) @(posedge aclk);
			chk(32'(tx_irq), 32'(i == 0));
		end
	endtask
	task finish_test;
		if (err_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// about 1100 cycles of work expected; 30000 cycles, over 25 times that, is a hang
	initial begin
		#3000000;
		err_count++;
		finish_test();
	end
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, idle_lvl} = '0;
		s_axi_wstrb = 4'hF;
		clr = 1'b1;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		clr <= 1'b0;
		t_regs();
		send(BASE, 8'hA5, 8, 9'h0A5);
		send(BASE | 32'h20, 8'h3C, 8, 9'h03C);
		send(BASE | 32'h180, 8'h81, 9, 9'h181);
		send(BASE | 32'hA0, 8'h7E, 9, 9'h07E);
		t_b2b();
		t_refuse();
		t_irq();
		finish_test();
	end
endmodule
